// file: bfsc_pkg.sv
// Shared constants, types and helper functions of the bridge fault and slew control block.
package bfsc_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int DEGLITCH_NS   = 500;
    localparam int OC_FILT_NS    = 2000;
    localparam int CORE_READY_NS = 40000;
    localparam int RETRY_NS      = 4000000;

    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int DEGLITCH_CYC   = cyc_up(DEGLITCH_NS);
    localparam int OC_FILT_CYC    = cyc_up(OC_FILT_NS);
    localparam int CORE_READY_CYC = cyc_up(CORE_READY_NS);
    localparam int RETRY_CYC_DEF  = cyc_up(RETRY_NS);

    // Slower edges hide more of the gate ramp inside the dead time.
    function automatic int dead_ns(input logic [2:0] code);
        case (code)
            3'h0:    return 200;
            3'h1:    return 250;
            3'h2:    return 350;
            3'h3:    return 450;
            3'h4:    return 550;
            3'h5:    return 700;
            3'h6:    return 900;
            default: return 1500;
        endcase
    endfunction

    function automatic logic [7:0] dead_cyc(input logic [2:0] code);
        return 8'(cyc_up(dead_ns(code)));
    endfunction

    // Strap states in order: ground, 22k down, 68k down, open, 51k up, rail.
    function automatic logic [2:0] strap_to_sr(input logic [2:0] strap);
        case (strap)
            3'h0:    return 3'h0;
            3'h1:    return 3'h1;
            3'h2:    return 3'h2;
            3'h4:    return 3'h5;
            3'h5:    return 3'h7;
            default: return 3'h3;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CTRL3     = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_ACTIVE    = 8'h0c;
    localparam int         CTRL_SR_LSB   = 0;
    localparam int         CTRL_POL_LSB  = 3;
    localparam int         CTRL_PCD_BIT  = 5;
    localparam int         CTRL_MODE_LSB = 6;
    localparam int         CLR_BIT       = 0;
    localparam logic [2:0] RST_SR        = 3'h0;
    localparam logic [1:0] RST_POL       = 2'h0;
    localparam logic       RST_PCD       = 1'b0;
    localparam logic [1:0] RST_MODE      = 2'h1;
    localparam logic [1:0] MODE_INDEP    = 2'h2;
    localparam logic [1:0] POL_LATCH     = 2'h0;
    localparam logic [1:0] POL_RETRY     = 2'h1;
    localparam logic [1:0] POL_REPORT    = 2'h2;
    localparam logic [1:0] POL_OFF       = 2'h3;

    typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_SLEEP} bfsc_st_e;
endpackage

// file: bfsc_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module bfsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bfsc_sync_s;

    bfsc_sync_s q;
    bfsc_sync_s next_q;

    always_comb begin
        next_q.s1 = d;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign q_out = q.s2;
endmodule

// file: bfsc_half_bridge.sv
// One half-bridge: input deglitch and break-before-make gate sequencing.
`timescale 1ns/1ps
module bfsc_half_bridge
    import bfsc_pkg::*;
#(
    parameter int DEGL_CYC = DEGLITCH_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       in_lvl,
    input  wire logic       enable,
    input  wire logic [7:0] dead,
    output logic            hs_on,
    output logic            ls_on
);
    typedef enum logic [1:0] {HB_OFF, HB_HIGH, HB_LOW, HB_DEAD} bfsc_hb_e;
    typedef struct packed {
        bfsc_hb_e   st;
        logic       lvl;
        logic [7:0] fcnt;
        logic [7:0] dcnt;
        logic       hs;
        logic       ls;
    } bfsc_hb_s;

    bfsc_hb_s q;
    bfsc_hb_s next_q;

    always_comb begin
        next_q = q;
        next_q.fcnt = 8'h0;
        if (in_lvl != q.lvl) begin
            next_q.fcnt = q.fcnt + 8'h1;
            if (q.fcnt == 8'(DEGL_CYC - 1)) begin
                next_q.lvl  = in_lvl;
                next_q.fcnt = 8'h0;
            end
        end
        case (q.st)
            HB_OFF: begin
                next_q.st   = HB_DEAD;
                next_q.dcnt = 8'h0;
            end
            HB_HIGH, HB_LOW: begin
                if (q.lvl != (q.st == HB_HIGH)) begin
                    next_q.st   = HB_DEAD;
                    next_q.dcnt = 8'h0;
                end
            end
            default: begin
                next_q.dcnt = q.dcnt + 8'h1;
                if (next_q.dcnt >= dead) begin
                    next_q.st = q.lvl ? HB_HIGH : HB_LOW;
                end
            end
        endcase
        if (!enable) begin
            next_q.st = HB_OFF;
        end
        next_q.hs = next_q.st == HB_HIGH;
        next_q.ls = next_q.st == HB_LOW;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{st: HB_OFF, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign hs_on = q.hs;
    assign ls_on = q.ls;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_bbm;
        (q.hs |=> !q.ls) and (q.ls |=> !q.hs);
    endproperty
    a_bbm: assert property (p_bbm) else $error("both transistors of a half-bridge on");

    sequence s_dead_start;
        (q.st == HB_HIGH || q.st == HB_LOW) ##1 (q.st == HB_DEAD);
    endsequence
    property p_dead_off;
        s_dead_start |-> (!q.hs && !q.ls) [*2];
    endproperty
    a_dead_off: assert property (p_dead_off) else $error("output driven during dead time");

    property p_dead_len;
        (q.st == HB_DEAD && enable && q.dcnt + 8'h1 < dead) |=> (q.st == HB_DEAD);
    endproperty
    a_dead_len: assert property (p_dead_len) else $error("dead time cut short");

    property p_deglitch;
        (in_lvl == q.lvl) |=> (q.lvl == $past(q.lvl));
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("level moved without a long input");
endmodule

// file: bfsc_top.sv
// Bridge fault, slew selection and sleep control with a Wishbone register slave.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module bfsc_top
    import bfsc_pkg::*;
#(
    parameter logic [19:0] RETRY_CYC = 20'(RETRY_CYC_DEF)
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_wdata,
    output logic      [31:0] wb_rdata,
    output logic             wb_ack,
    input  wire logic [1:0]  drive_inputs,
    input  wire logic        low_power_request_n,
    input  wire logic        supply_low_det,
    input  wire logic        pump_low_det,
    input  wire logic [3:0]  oc_det,
    input  wire logic [2:0]  slew_strap,
    input  wire logic        serial_variant,
    input  wire logic        fault_indicator_n_in,
    output logic             fault_indicator_n_out,
    output logic             fault_indicator_n_oe,
    output logic      [1:0]  high_side_on,
    output logic      [1:0]  low_side_on,
    output logic      [2:0]  edge_rate_out,
    output logic             pump_enable,
    output logic             serial_out_enable
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        bfsc_st_e         st;
        logic [12:0]      init_cnt;
        logic [2:0]       sr_reg;
        logic [1:0]       pol;
        logic             pcd;
        logic [1:0]       mode;
        logic             variant;
        logic [2:0]       strap;
        logic             summary;
        logic             supply_low;
        logic             pump_low;
        logic [1:0]       oc_flag;
        logic [1:0]       oc_hold;
        logic [1:0][7:0]  oc_cnt;
        logic [1:0][19:0] retry_cnt;
        logic [2:0]       rate_out;
        logic [7:0]       dead;
        logic [1:0]       bridge_en;
        logic             fault_lvl;
        logic             fault_oe;
        logic             pump_en;
        logic             sdo_en;
        logic             ack;
        logic [31:0]      rdata;
    } bfsc_top_s;

    bfsc_top_s   q;
    bfsc_top_s   next_q;
    logic [13:0] sync_q;
    logic [1:0]  in_s;
    logic        lpr_s;
    logic        sleep_req_s;
    logic        uv_s;
    logic        cpd_s;
    logic [3:0]  oc_s;
    logic [2:0]  strap_s;
    logic        variant_s;
    logic        fault_in_s;
    logic [1:0]  oc_h;
    logic        run;
    logic        cp;
    logic        wr;
    logic        clr;
    logic [1:0]  trip;
    logic [1:0]  shut;

    bfsc_sync #(
        .W (14)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .d     ({fault_indicator_n_in, serial_variant, slew_strap, oc_det,
                 pump_low_det, supply_low_det, !low_power_request_n, drive_inputs}),
        .q_out (sync_q)
    );

    assign {fault_in_s, variant_s, strap_s, oc_s, cpd_s, uv_s, sleep_req_s, in_s} = sync_q;
    // The sleep request travels inverted, so a flushed synchroniser reads as awake.
    // Otherwise reset would look like a sleep pulse and release the fault line early.
    assign lpr_s = !sleep_req_s;
    assign oc_h = {oc_s[3] | oc_s[2], oc_s[1] | oc_s[0]};
    assign run  = q.st == ST_RUN;
    assign cp   = cpd_s && !q.pcd;
    assign wr   = wb_cyc && wb_stb && wb_we && !q.ack && wb_sel[0];
    // A sleep pulse clears faults exactly like the clear bit.
    assign clr  = (wr && wb_adr == OFS_CTRL3 && wb_wdata[CLR_BIT]) ||
                  (q.st != ST_SLEEP && !lpr_s);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic rel;
        rel    = 1'b0;
        next_q = q;
        trip   = 2'b00;
        shut   = 2'b00;

        next_q.ack = wb_cyc && wb_stb && !q.ack;
        if (wr && wb_adr == OFS_CTRL) begin
            next_q.sr_reg = wb_wdata[CTRL_SR_LSB +: 3];
            next_q.pol    = wb_wdata[CTRL_POL_LSB +: 2];
            next_q.pcd    = wb_wdata[CTRL_PCD_BIT];
            next_q.mode   = wb_wdata[CTRL_MODE_LSB +: 2];
        end
        case (wb_adr)
            OFS_CTRL:   next_q.rdata = {24'h0, q.mode, q.pcd, q.pol, q.sr_reg};
            OFS_STATUS: next_q.rdata = {24'h0, fault_in_s, q.st == ST_SLEEP, run,
                                        q.oc_flag, q.pump_low, q.supply_low, q.summary};
            OFS_ACTIVE: next_q.rdata = {28'h0, q.variant, q.rate_out};
            default:    next_q.rdata = 32'h0;
        endcase

        case (q.st)
            ST_SLEEP: begin
                next_q.st       = ST_INIT;
                next_q.init_cnt = 13'h0;
            end
            ST_INIT: begin
                next_q.init_cnt = q.init_cnt + 13'h1;
                if (q.init_cnt == 13'(CORE_READY_CYC - 1)) begin
                    next_q.st      = ST_RUN;
                    next_q.strap   = strap_s;
                    next_q.variant = variant_s;
                end
            end
            default: ;
        endcase
        if (!lpr_s) begin
            next_q.st = ST_SLEEP;
        end

        // Set terms come last so that an event in the clear cycle survives.
        next_q.supply_low = (q.supply_low && !(clr && !uv_s)) || (run && uv_s);
        next_q.pump_low   = (q.pump_low && !(clr && !cp)) || (run && cp);

        for (int h = 0; h < 2; h++) begin
            if (!oc_h[h]) begin
                next_q.oc_cnt[h] = 8'h0;
            end else if (q.oc_cnt[h] != 8'(OC_FILT_CYC)) begin
                next_q.oc_cnt[h] = q.oc_cnt[h] + 8'h1;
            end
            trip[h] = run && oc_h[h] && q.oc_cnt[h] == 8'(OC_FILT_CYC) &&
                      q.pol != POL_OFF;
            if (trip[h]) begin
                next_q.retry_cnt[h] = RETRY_CYC;
            end else if (q.retry_cnt[h] != 20'h0) begin
                next_q.retry_cnt[h] = q.retry_cnt[h] - 20'h1;
            end
            if (q.pol == POL_RETRY) begin
                rel = q.retry_cnt[h] == 20'h0 && !oc_h[h];
            end else begin
                rel = q.pol == POL_OFF || (clr && !oc_h[h]);
            end
            next_q.oc_hold[h] = (q.oc_hold[h] && !rel) || trip[h];
            next_q.oc_flag[h] = (q.oc_flag[h] && !(clr && !oc_h[h])) || trip[h];
            shut[h] = (q.oc_hold[h] || trip[h]) &&
                      (q.pol == POL_LATCH || q.pol == POL_RETRY);
        end
        // Outside independent mode the two halves form one bridge and stop together.
        if (q.mode != MODE_INDEP && shut != 2'b00) begin
            shut = 2'b11;
        end

        next_q.summary = (q.summary && !(clr && !uv_s && !cp && oc_h == 2'b00)) ||
                         (run && (uv_s || cp)) || trip != 2'b00;
        next_q.bridge_en = {2{run && lpr_s && !uv_s && !cp}} & ~shut;
        next_q.fault_oe  = next_q.st == ST_INIT ||
                           (next_q.st == ST_RUN &&
                            (uv_s || cp || next_q.oc_hold != 2'b00));
        next_q.fault_lvl = 1'b0;
        next_q.pump_en   = lpr_s && !uv_s;
        next_q.sdo_en    = lpr_s;
        next_q.rate_out  = q.variant ? q.sr_reg : strap_to_sr(q.strap);
        next_q.dead      = dead_cyc(q.rate_out);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{st: ST_INIT, sr_reg: RST_SR, pol: RST_POL, pcd: RST_PCD,
                   mode: RST_MODE, strap: 3'h3, rate_out: 3'h3,
                   dead: 8'h14, fault_oe: 1'b1, default: '0};
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------
    // Half-bridges
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_hb
        bfsc_half_bridge u_hb (
            .clk    (clk),
            .rst    (rst),
            .in_lvl (in_s[g]),
            .enable (q.bridge_en[g]),
            .dead   (q.dead),
            .hs_on  (high_side_on[g]),
            .ls_on  (low_side_on[g])
        );
    end

    assign wb_rdata              = q.rdata;
    assign wb_ack                = q.ack;
    assign fault_indicator_n_out = q.fault_lvl;
    assign fault_indicator_n_oe  = q.fault_oe;
    assign edge_rate_out         = q.rate_out;
    assign pump_enable           = q.pump_en;
    assign serial_out_enable     = q.sdo_en;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_live;
        run && lpr_s;
    endsequence

    property p_uv_stop;
        (s_live and uv_s) |=> (q.fault_oe && !q.pump_en && q.bridge_en == 2'b00 &&
                               q.supply_low && q.summary);
    endproperty
    a_uv_stop: assert property (p_uv_stop) else $error("undervoltage not handled");

    property p_flag_hold;
        (q.supply_low && !clr |=> q.supply_low) and (q.pump_low && !clr |=> q.pump_low);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

    property p_pump_uv;
        (s_live and (cp && !uv_s)) |=> (q.pump_en && q.fault_oe &&
                                        q.bridge_en == 2'b00 && q.pump_low);
    endproperty
    a_pump_uv: assert property (p_pump_uv) else $error("pump undervoltage not handled");

    property p_recover;
        (s_live and (!uv_s && !cp && q.oc_hold == 2'b00 && q.oc_cnt == 16'h0))
            |=> (q.bridge_en == 2'b11 && !q.fault_oe);
    endproperty
    a_recover: assert property (p_recover) else $error("no automatic resume");

    property p_pcd;
        (q.pcd && !q.pump_low) |=> !q.pump_low;
    endproperty
    a_pcd: assert property (p_pcd) else $error("pump check ran while disabled");

    sequence s_oc_latch;
        s_live and (!uv_s && oc_h[0] && q.oc_cnt[0] == 8'(OC_FILT_CYC) && q.pol == POL_LATCH);
    endsequence
    property p_oc_latch;
        s_oc_latch |=> (q.oc_flag[0] && !q.bridge_en[0] && q.fault_oe && q.pump_en);
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");

    property p_oc_retry;
        (q.pol == POL_RETRY && q.oc_hold[0] && q.retry_cnt[0] != 20'h0) |=> q.oc_hold[0];
    endproperty
    a_oc_retry: assert property (p_oc_retry) else $error("retry released early");

    property p_oc_report;
        (s_live and (!uv_s && !cp && q.pol == POL_REPORT)) |=> q.bridge_en == 2'b11;
    endproperty
    a_oc_report: assert property (p_oc_report) else $error("report policy stopped drive");

    property p_oc_off;
        (q.pol == POL_OFF && q.oc_flag == 2'b00) |=> q.oc_flag == 2'b00;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("disabled policy reported");

    property p_indep;
        (s_live and (!uv_s && !cp && q.mode == MODE_INDEP && !q.oc_hold[1] &&
                     q.oc_cnt[1] == 8'h0)) |=> q.bridge_en[1];
    endproperty
    a_indep: assert property (p_indep) else $error("healthy half stopped");

    property p_clr_keep;
        (clr && oc_h[0] && q.oc_flag[0]) |=> q.oc_flag[0];
    endproperty
    a_clr_keep: assert property (p_clr_keep) else $error("clear dropped live fault");

    property p_rate;
        (q.variant |=> q.rate_out == $past(q.sr_reg)) and
        (!q.variant |=> q.rate_out == strap_to_sr($past(q.strap)));
    endproperty
    a_rate: assert property (p_rate) else $error("wrong slew setting");

    property p_init_fault;
        (q.st == ST_INIT) |-> q.fault_oe;
    endproperty
    a_init_fault: assert property (p_init_fault) else $error("fault released before ready");

    property p_sleep;
        !lpr_s |=> (q.st == ST_SLEEP && !q.sdo_en && q.bridge_en == 2'b00);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
endmodule

// file: bfsc_host.sv
// Host model: input pins, sleep request and the pulled-up fault wire.
`timescale 1ns/1ps
module bfsc_host (
    input  wire logic       clk,
    input  wire logic       oe,
    output logic            fault_wire,
    output logic [1:0]      drive_inputs,
    output logic            low_power_request_n
);
    // The pull-up takes the wire high as soon as the device lets go.
    assign fault_wire = oe ? 1'b0 : 1'b1;
    initial begin
        drive_inputs = 2'h0;
        low_power_request_n = 1'b1;
    end
    task automatic drv(input logic [1:0] v);
        @(posedge clk);
        drive_inputs <= v;
    endtask
    // Faults are cleared with the clear bit or by a sleep pulse, which also requests low power.
    task automatic slp(input logic v);
        @(posedge clk);
        low_power_request_n <= v;
    endtask
endmodule

// file: bfsc_top_tb.sv
// Self-checking bench of the bridge fault and slew control block.
`timescale 1ns/1ps
module bfsc_top_tb
    import bfsc_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ack, uv, cp, sv, fw, foe, pe, soe, lprn, fo;
    logic [7:0]  adr;
    logic [31:0] wd, rd, rv;
    logic [3:0]  oc, sel;
    logic [2:0]  strap, er;
    logic [1:0]  di, hs, ls;
    int          errors, tests_run, k, g0, g1;
    logic [2:0]  scode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    logic [7:0]  occ [5] = '{8'h40, 8'h48, 8'h50, 8'h58, 8'h80};
    logic [3:0]  oce [5] = '{4'b1001, 4'b1000, 4'b1111, 4'b0110, 4'b1101};
    bfsc_top #(.RETRY_CYC(20'd50)) bfsc_top_i (
        .clk(clk), .rst(rst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
        .wb_sel(sel), .wb_wdata(wd), .wb_rdata(rd), .wb_ack(ack), .drive_inputs(di),
        .low_power_request_n(lprn), .supply_low_det(uv), .pump_low_det(cp), .oc_det(oc),
        .slew_strap(strap), .serial_variant(sv), .fault_indicator_n_in(fw),
        .fault_indicator_n_out(fo), .fault_indicator_n_oe(foe), .high_side_on(hs),
        .low_side_on(ls), .edge_rate_out(er), .pump_enable(pe), .serial_out_enable(soe));
    bfsc_host bfsc_host_i (.clk(clk), .oe(foe), .fault_wire(fw), .drive_inputs(di),
        .low_power_request_n(lprn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            errors++;
            final_report();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        tmo(ack);
        rv = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_ready;
        for (k = 0; foe !== 1'b0 && k < 5000; k++) @(posedge clk);
        tmo(foe === 1'b0);
    endtask
    // Counts the cycles with the low side off before the high side turns on.
    task automatic gap(output int g);
        bfsc_host_i.drv(2'h1);
        g = 0;
        for (k = 0; hs[0] !== 1'b1 && k < 400; k++) begin
            @(posedge clk);
            g += (ls[0] === 1'b0);
        end
        chk("hs_on", hs[0], 32'h1);
        bfsc_host_i.drv(2'h0);
        repeat (400) @(posedge clk);
    endtask
    always @(negedge clk) begin
        if (!rst) begin
            chk("overlap", hs & ls, 32'h0);
        end
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, uv, cp, adr, wd, oc, strap} = '0;
        sv = 1'b1;
        sel = 4'hf;
        errors = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        g1 = 0;
        repeat (100) @(posedge clk) g1 += (foe !== 1'b1);
        chk("init_hold", g1, 32'h0);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", rv, 32'h40);
        sel <= 4'he;
        bus(1'b1, OFS_CTRL, 32'h47);
        sel <= 4'hf;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk("sel_ignored", rv, 32'h40);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", rv, 32'h0);
        wait_ready();
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, OFS_CTRL, 32'h40 | c);
            bus(1'b0, OFS_ACTIVE, 32'h0);
            chk("active_rate", rv, 32'h8 | c);
            chk("edge_rate", er, c);
        end
        gap(g0);
        bus(1'b1, OFS_CTRL, 32'h40);
        gap(g1);
        chk("dead_order", g0 > g1 && g1 > 0, 32'h1);
        bfsc_host_i.drv(2'h1);
        repeat (20) @(posedge clk);
        bfsc_host_i.drv(2'h0);
        g1 = 0;
        repeat (120) @(posedge clk) g1 += (ls[0] !== 1'b1);
        chk("deglitch", g1, 32'h0);
        $display("slew and drive tests done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {cp, uv} <= i ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk);
            chk("uv_fault", foe, 32'h1);
            chk("uv_pump", pe, i);
            chk("uv_gates", {hs, ls}, 32'h0);
            bus(1'b1, OFS_CTRL3, 32'h1);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("uv_flags", rv & 32'h7, i ? 32'h5 : 32'h3);
            {cp, uv} <= 2'b00;
            repeat (6) @(posedge clk);
            chk("uv_back", foe, 32'h0);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("uv_keep", rv & 32'h7, i ? 32'h5 : 32'h3);
            bus(1'b1, OFS_CTRL3, 32'h1);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("uv_clr", rv & 32'h7, 32'h0);
        end
        bus(1'b1, OFS_CTRL, 32'h60);
        cp <= 1'b1;
        repeat (6) @(posedge clk);
        chk("pcd_fault", foe, 32'h0);
        cp <= 1'b0;
        repeat (4) @(posedge clk);
        $display("supply tests done");
        for (int p = 0; p < 5; p++) begin
            bus(1'b1, OFS_CTRL, {24'h0, occ[p]});
            oc <= 4'h1;
            repeat (220) @(posedge clk);
            chk("oc_fault", foe, oce[p][3]);
            chk("fault_data", fo, 32'h0);
            chk("oc_drive", ls, oce[p][2:1]);
            oc <= 4'h0;
            repeat (100) @(posedge clk);
            chk("oc_hold", foe, oce[p][0]);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk("oc_status", rv[7:3], {!oce[p][0], 3'b010, oce[p][3]});
            bus(1'b1, OFS_CTRL3, 32'h1);
            repeat (100) @(posedge clk);
            chk("oc_clr", foe, 32'h0);
        end
        $display("overcurrent tests done");
        sv <= 1'b0;
        for (int s = 0; s < 6; s++) begin
            strap <= s[2:0];
            bfsc_host_i.slp(1'b0);
            repeat (6) @(posedge clk);
            chk("sleep_sdo", soe, 32'h0);
            chk("sleep_fault", foe, 32'h0);
            bfsc_host_i.slp(1'b1);
            repeat (6) @(posedge clk);
            chk("wake_hold", foe, 32'h1);
            wait_ready();
            bus(1'b0, OFS_ACTIVE, 32'h0);
            chk("strap_rate", rv, {29'h0, scode[s]});
            chk("wake_sdo", soe, 32'h1);
        end
        $display("sleep and strap tests done");
        final_report();
    end
endmodule
